/* design/eesc_prog_timer.v */
// self-timed program cycle counter
`include "eesc_regs.vh"
module eesc_prog_timer #(
    parameter [`EESC_PROG_CNT_W-1:0] PROG_CYCLES = `EESC_PROG_CYCLES
) (
    // clock and reset
    input  wire clock,
    input  wire rst,
    // control
    input  wire start,
    output wire busy
);

    reg [`EESC_PROG_CNT_W-1:0] remain;

    // once loaded the count runs out regardless of select or guard pin
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            remain <= {`EESC_PROG_CNT_W{1'b0}};
        end else if (start && remain == {`EESC_PROG_CNT_W{1'b0}}) begin
            remain <= PROG_CYCLES;
        end else if (remain != {`EESC_PROG_CNT_W{1'b0}}) begin
            remain <= remain - 1'b1;
        end
    end

    assign busy = (remain != {`EESC_PROG_CNT_W{1'b0}});

endmodule // eesc_prog_timer

/* design/eesc_regs.vh */
// constants shared by the serial eeprom slave control files
`ifndef EESC_REGS_VH
`define EESC_REGS_VH

// serial command bytes
`define EESC_OP_WRSR        8'h01
`define EESC_OP_WRITE       8'h02
`define EESC_OP_READ        8'h03
`define EESC_OP_WRDI        8'h04
`define EESC_OP_RDSR        8'h05
`define EESC_OP_UNLOCK      8'h06

// status byte layout
`define EESC_SR_BUSY        0
`define EESC_SR_LATCH       1
`define EESC_SR_BP_LO       2
`define EESC_SR_BP_HI       3
`define EESC_SR_HONOUR      7
`define EESC_SR_UNUSED      3'h7
`define EESC_SR_BP_RESET    2'h0
`define EESC_SR_HON_RESET   1'b0

// block protection codes
`define EESC_BP_QUARTER     2'h1
`define EESC_BP_HALF        2'h2
`define EESC_BP_ALL         2'h3

// apb register offsets and fields
`define EESC_OFF_STATUS     12'h000
`define EESC_OFF_CONFIG     12'h004
`define EESC_OFF_LAUNCHES   12'h008
`define EESC_CFG_HOLD_EN    0
`define EESC_CFG_RESET      1'b1
`define EESC_ST_STANDBY     8
`define EESC_ST_ARMED       9
`define EESC_ST_PAUSED      10

// program cycle timing
`define EESC_CLK_PERIOD_NS  8
`define EESC_PROG_TIME_US   5000
`define EESC_PROG_CNT_W     20
`define EESC_PROG_CYCLES    20'h9_8968 // 5000 us over 8 ns, sized to the counter

`endif

/* design/eesc_sync.v */
// two flip-flop synchronisers for the serial pins
module eesc_sync #(
    parameter WIDTH = 5
) (
    // clock and reset
    input  wire             clock,
    input  wire             rst,
    // pins in, synchronised levels out
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;

    // one pair of flops per pin; the first is read only by the second
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta;
            reg stable;
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    meta   <= 1'b0;
                    stable <= 1'b0;
                end else begin
                    meta   <= async_in[i];
                    stable <= meta;
                end
            end
            assign sync_out[i] = stable;
        end
    endgenerate

endmodule // eesc_sync

/* design/eesc_top.v */
// serial eeprom slave control: spi pin engine, guard logic, array, apb view
// How it works
// (RULE1) data in sampled on clock rising edge
// (RULE2) data out changes on clock falling edge
// (RULE3) only modes 0,0 and 1,1 supported
// (RULE4) respond only while select is low
// (RULE5) deselected and idle means standby
// (RULE6) ignore bus until first select fall
// (RULE7) select rise after valid write starts programming
// (RULE8) program cycle finishes whatever select does
// (RULE9) data out floats while deselected
// (RULE10) guard pin high allows status writes
// (RULE11) guard low blocks status, not array writes
// (RULE12) guard pin change cannot abort programming
// (RULE13) honour bit zero ignores guard pin
// (RULE14) honour bit not clearable while guard low
// (RULE15) write one to thirty-two bytes per page
// (RULE16) self-timed cycle with erase, about 5 ms
// (RULE17) block protect quarter, half or whole array
// (RULE18) busy flag is status bit zero
// (RULE19) writes need unlock command setting latch flag
// (RULE20) hold pauses transfer, data out floats
// (RULE21) most significant bit first both ways
// (RULE22) select fall resets decoder, partial bytes dropped
// (RULE23) master polls busy before next write
//
// The register offsets and register access over APB are this design's own decisions.
`include "eesc_regs.vh"
module eesc_top #(
    parameter [`EESC_PROG_CNT_W-1:0] PROG_CYCLES = `EESC_PROG_CYCLES
) (
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // serial pins
    input  wire        device_select_n,
    input  wire        serial_clock_in,
    input  wire        serial_data_in,
    input  wire        hold_n,
    input  wire        write_guard_pin_n,
    output wire        serial_data_out,
    output wire        serial_data_out_oe,
    // state
    output wire        program_busy,
    output wire        standby,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr
);

    // protocol phases
    localparam [2:0] ST_CMD  = 3'd0;
    localparam [2:0] ST_ADH  = 3'd1;
    localparam [2:0] ST_ADL  = 3'd2;
    localparam [2:0] ST_WDAT = 3'd3;
    localparam [2:0] ST_RDAT = 3'd4;
    localparam [2:0] ST_SRD  = 3'd5;
    localparam [2:0] ST_SRW  = 3'd6;
    localparam [2:0] ST_IGN  = 3'd7;

    wire       cs_n_s;
    wire       sck_s;
    wire       si_s;
    wire       hold_n_s;
    wire       wp_n_s;
    reg        sck_d;
    reg        cs_d;
    reg        seen_high;
    reg        armed;
    reg        paused;
    reg        hold_en;
    reg  [2:0] phase;
    reg  [2:0] bit_cnt;
    reg  [6:0] rx_sh;
    reg        op_read;
    reg  [9:0] addr;
    reg  [7:0] tx_sh;
    reg        tx_on;
    reg        so_q;
    reg        latch;
    reg        honour;
    reg  [1:0] bp;
    reg  [7:0] sr_stage;
    reg        sr_pend;
    reg  [31:0] page_mask;
    reg  [31:0] commit_mask;
    reg  [4:0] page_no;
    reg        committing;
    reg  [4:0] commit_idx;
    reg        busy_d;
    reg  [15:0] launches;
    reg  [7:0] mem [0:1023];
    reg  [7:0] page_buf [0:31];
    wire       busy;

    // pin synchronisers
    eesc_sync #(
        .WIDTH    (5)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in ({device_select_n, serial_clock_in, serial_data_in,
                    hold_n, write_guard_pin_n}),
        .sync_out ({cs_n_s, sck_s, si_s, hold_n_s, wp_n_s})
    );

    // edges of the synchronised serial clock and select
    wire sck_rise = sck_s & ~sck_d;
    wire sck_fall = ~sck_s & sck_d;
    wire cs_fall  = ~cs_n_s & cs_d;
    wire cs_rise  = cs_n_s & ~cs_d;

    // engine acts only when selected, armed and not paused
    wire active    = ~cs_n_s & armed & ~paused; // see (RULE4)
    wire [7:0] next_rx  = {rx_sh, si_s}; // see (RULE21)
    wire byte_done = sck_rise & active & (bit_cnt == 3'd7);
    wire [7:0] status_byte = {honour, `EESC_SR_UNUSED, bp, latch, busy}; // see (RULE18)
    wire [9:0] adl_addr = {addr[9:8], next_rx};
    wire [9:0] addr_inc = addr + 10'h001;

    // guard pin counts only when the honour bit is set
    wire sr_refused = honour & ~wp_n_s; // see (RULE11) see (RULE13) see (RULE14)
    wire wr_ok      = (phase == ST_WDAT) & (page_mask != 32'h0000_0000);
    wire sr_ok      = sr_pend & ~sr_refused; // see (RULE10)
    wire start      = cs_rise & armed & ~busy & (bit_cnt == 3'd0)
                      & (wr_ok | sr_ok); // see (RULE7) see (RULE22)

    // true when the address falls in a protected block
    function prot;
        input [1:0] code;
        input [9:0] a;
        begin
            prot = (code == `EESC_BP_ALL)
                 | ((code == `EESC_BP_HALF) & a[9])
                 | ((code == `EESC_BP_QUARTER) & (a[9:8] == 2'h3));
        end
    endfunction

    // program cycle timer, blind to select and guard once started
    eesc_prog_timer #(
        .PROG_CYCLES (PROG_CYCLES)
    ) u_timer (
        .clock       (clock),
        .rst         (rst),
        .start       (start),
        .busy        (busy) // see (RULE8) see (RULE12) see (RULE16)
    );

    // edge history, power-up arming and hold pause
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            sck_d     <= 1'b0;
            cs_d      <= 1'b0;
            seen_high <= 1'b0;
            armed     <= 1'b0;
            paused    <= 1'b0;
        end else begin
            sck_d <= sck_s;
            cs_d  <= cs_n_s;
            if (cs_n_s) begin
                seen_high <= 1'b1;
            end
            if (cs_fall && seen_high) begin
                armed <= 1'b1; // see (RULE6)
            end
            if (cs_n_s) begin
                paused <= 1'b0;
            end else if (!sck_s) begin
                paused <= hold_en & ~hold_n_s; // see (RULE20)
            end
        end
    end

    // serial protocol engine
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            phase     <= ST_CMD;
            bit_cnt   <= 3'd0;
            rx_sh     <= 7'h00;
            op_read   <= 1'b0;
            addr      <= 10'h000;
            tx_sh     <= 8'h00;
            tx_on     <= 1'b0;
            so_q      <= 1'b0;
            latch     <= 1'b0;
            honour    <= `EESC_SR_HON_RESET;
            bp        <= `EESC_SR_BP_RESET;
            sr_stage  <= 8'h00;
            sr_pend   <= 1'b0;
            page_mask <= 32'h0000_0000;
            page_no   <= 5'h00;
            busy_d    <= 1'b0;
        end else begin
            busy_d <= busy;
            if (busy_d && !busy) begin
                latch <= 1'b0;
            end
            if (start && sr_pend) begin
                bp     <= sr_stage[`EESC_SR_BP_HI:`EESC_SR_BP_LO];
                honour <= sr_stage[`EESC_SR_HONOUR];
            end
            if (cs_n_s) begin
                tx_on <= 1'b0; // see (RULE9)
            end
            if (cs_fall) begin
                phase     <= ST_CMD; // see (RULE22)
                bit_cnt   <= 3'd0;
                sr_pend   <= 1'b0;
                page_mask <= 32'h0000_0000;
            end else if (sck_rise && active) begin
                bit_cnt <= bit_cnt + 3'd1; // see (RULE1) see (RULE3)
                rx_sh   <= next_rx[6:0];
                if (bit_cnt == 3'd7) begin
                    case (phase)
                        ST_CMD: begin
                            phase   <= ST_IGN;
                            op_read <= (next_rx == `EESC_OP_READ);
                            if (next_rx == `EESC_OP_RDSR) begin
                                phase <= ST_SRD;
                                tx_sh <= status_byte;
                                tx_on <= 1'b1;
                            end else if (!busy) begin
                                if (next_rx == `EESC_OP_UNLOCK) begin
                                    latch <= 1'b1; // see (RULE19)
                                end else if (next_rx == `EESC_OP_WRDI) begin
                                    latch <= 1'b0;
                                end else if (next_rx == `EESC_OP_READ) begin
                                    phase <= ST_ADH;
                                end else if (latch && next_rx == `EESC_OP_WRITE) begin
                                    phase <= ST_ADH; // see (RULE19)
                                end else if (latch && next_rx == `EESC_OP_WRSR) begin
                                    phase <= ST_SRW;
                                end
                            end
                        end
                        ST_ADH: begin
                            addr[9:8] <= next_rx[1:0];
                            phase     <= ST_ADL;
                        end
                        ST_ADL: begin
                            addr <= adl_addr;
                            if (op_read) begin
                                phase <= ST_RDAT;
                                tx_sh <= mem[adl_addr];
                                tx_on <= 1'b1;
                            end else if (prot(bp, adl_addr)) begin
                                phase <= ST_IGN; // see (RULE17)
                            end else begin
                                phase   <= ST_WDAT;
                                page_no <= adl_addr[9:5];
                            end
                        end
                        ST_WDAT: begin
                            page_mask[addr[4:0]] <= 1'b1; // see (RULE15)
                            addr[4:0]            <= addr[4:0] + 5'h01;
                        end
                        ST_RDAT: begin
                            addr  <= addr_inc;
                            tx_sh <= mem[addr_inc];
                        end
                        ST_SRD: begin
                            tx_sh <= status_byte;
                        end
                        ST_SRW: begin
                            sr_stage <= next_rx;
                            sr_pend  <= 1'b1;
                            phase    <= ST_IGN;
                        end
                        default: begin
                            phase <= ST_IGN;
                        end
                    endcase
                end
            end else if (sck_fall && active && tx_on) begin
                so_q  <= tx_sh[7]; // see (RULE2) see (RULE21)
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
        end
    end

    // page buffer capture of each complete data byte
    always @(posedge clock) begin
        if (byte_done && phase == ST_WDAT) begin
            page_buf[addr[4:0]] <= next_rx;
        end
    end

    // array commit, one buffered byte per clock at the start of the cycle
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            committing  <= 1'b0;
            commit_idx  <= 5'h00;
            commit_mask <= 32'h0000_0000;
            launches    <= 16'h0000;
        end else if (start) begin
            committing  <= wr_ok;
            commit_idx  <= 5'h00;
            commit_mask <= wr_ok ? page_mask : 32'h0000_0000;
            launches    <= launches + 16'h0001;
        end else if (committing) begin
            commit_idx <= commit_idx + 5'h01;
            if (commit_idx == 5'h1f) begin
                committing <= 1'b0;
            end
        end
    end

    // array write port
    always @(posedge clock) begin
        if (committing && commit_mask[commit_idx]) begin
            mem[{page_no, commit_idx}] <= page_buf[commit_idx]; // see (RULE16)
        end
    end

    // apb decode; zero wait states, unmapped offsets answer with an error
    wire apb_hit = (paddr == `EESC_OFF_STATUS) | (paddr == `EESC_OFF_CONFIG)
                   | (paddr == `EESC_OFF_LAUNCHES);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~apb_hit;

    // config write in the access cycle, read data capture in the setup cycle
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            hold_en <= `EESC_CFG_RESET;
            prdata  <= 32'h0000_0000;
        end else begin
            if (psel && penable && pwrite && paddr == `EESC_OFF_CONFIG) begin
                hold_en <= pwdata[`EESC_CFG_HOLD_EN];
            end
            if (psel && !penable) begin
                case (paddr)
                    `EESC_OFF_STATUS:   prdata <= {21'h00_0000, paused, armed,
                                                   standby, status_byte};
                    `EESC_OFF_CONFIG:   prdata <= {31'h0000_0000, hold_en};
                    `EESC_OFF_LAUNCHES: prdata <= {16'h0000, launches};
                    default:            prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // pin and state outputs
    assign serial_data_out    = so_q;
    assign serial_data_out_oe = active & tx_on; // see (RULE9) see (RULE20)
    assign program_busy       = busy;
    assign standby            = cs_n_s & ~busy; // see (RULE5) see (RULE8)

endmodule // eesc_top

/* verif/eesc_spi_master_model.sv */
// spi master model driving the serial eeprom slave pins
module eesc_spi_master_model (
    // clock
    input  wire clock,
    // pins toward the slave
    output reg  device_select_n,
    output reg  serial_clock_in,
    output reg  serial_data_in,
    output reg  hold_n,
    // data back from the slave
    input  wire serial_data_out,
    input  wire serial_data_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cpol = 1'b0;
    logic line_last = 1'b0;
    // select low from power up, so no falling edge is seen at first
    initial begin
        device_select_n = 1'b0;
        serial_clock_in = 1'b0;
        serial_data_in = 1'b0;
        hold_n = 1'b1;
    end
    // idle clock level picks mode 0,0 or 1,1
    task set_mode(input logic pol);
        @(posedge clock);
        cpol <= pol;
        serial_clock_in <= pol;
    endtask
    task begin_frame;
        @(posedge clock);
        device_select_n <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    // n bits msb first; a released line reads as the inverse of the last bit
    task xfer(input int n, input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            serial_clock_in <= 1'b0;
            serial_data_in <= tx[i];
            repeat (5) @(posedge clock);
            line_last = (serial_data_out_oe === 1'b1) ? serial_data_out : ~line_last;
            rx[i] = line_last;
            serial_clock_in <= 1'b1;
            repeat (3) @(posedge clock);
        end
    endtask
    // clock back to idle before select rises, so no stray edge ends a byte
    task end_frame;
        serial_clock_in <= cpol;
        repeat (4) @(posedge clock);
        device_select_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask
    // hold only moves while the clock is low
    task set_hold(input logic lvl);
        serial_clock_in <= 1'b0;
        repeat (4) @(posedge clock);
        hold_n <= lvl;
        repeat (8) @(posedge clock);
    endtask
endmodule // eesc_spi_master_model

/* verif/eesc_top_properties.sv */
// concurrent properties on the serial eeprom slave control ports
`include "eesc_regs.vh"
module eesc_props #(
    parameter [`EESC_PROG_CNT_W-1:0] PROG_CYCLES = `EESC_PROG_CYCLES
) (
    // clock and reset
    input wire        clock,
    input wire        rst,
    // serial pins
    input wire        device_select_n,
    input wire        serial_clock_in,
    input wire        hold_n,
    input wire        serial_data_out,
    input wire        serial_data_out_oe,
    // state
    input wire        program_busy,
    input wire        standby,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    reg  [`EESC_PROG_CNT_W-1:0] busy_run;
    wire                        mapped;
    // offsets that answer without an error
    assign mapped = paddr == `EESC_OFF_STATUS || paddr == `EESC_OFF_CONFIG
                    || paddr == `EESC_OFF_LAUNCHES;
    // cycles spent busy in the current program cycle
    always @(posedge clock or posedge rst) begin
        if (rst)
            busy_run <= 20'h0_0000;
        else if (program_busy)
            busy_run <= busy_run + 20'h0_0001;
        else
            busy_run <= 20'h0_0000;
    end
    sequence s_away;
        device_select_n [*5];
    endsequence
    sequence s_here;
        !device_select_n [*5];
    endsequence
    sequence s_pause;
        (!hold_n && !serial_clock_in) [*6];
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    chk_oe_released: assert property (s_away |-> !serial_data_out_oe)
        else $error("data out driven while deselected");
    chk_standby_idle: assert property (s_away ##0 !program_busy |-> standby)
        else $error("no standby while deselected and idle");
    chk_select_wakes: assert property (s_here |-> !standby)
        else $error("standby while selected");
    chk_busy_length: assert property ($fell(program_busy) |-> busy_run == PROG_CYCLES)
        else $error("program cycle length wrong");
    chk_busy_runs: assert property ($rose(program_busy) |-> program_busy [*8])
        else $error("program cycle cut short");
    chk_launch_cause: assert property ($rose(program_busy) |->
        device_select_n && $past(device_select_n, 2))
        else $error("program cycle started while selected");
    chk_out_on_fall: assert property (serial_data_out_oe && $changed(serial_data_out) |->
        !$past(serial_clock_in, 2))
        else $error("data out changed away from a clock fall");
    chk_pause_floats: assert property (s_pause |-> !serial_data_out_oe)
        else $error("data out driven while paused");
    chk_apb_answer: assert property (s_access |-> pready && (pslverr == !mapped))
        else $error("apb answer wrong");
    chk_unmapped_zero: assert property (s_access ##0 !pwrite && !mapped |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule // eesc_props

/* verif/eesc_top_tb_top.sv */
// self-checking bench for the serial eeprom slave control block
module eesc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [39:0] UNLOCK = 40'h06_0000_0000;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        write_guard_pin_n = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  rx;
    wire         device_select_n, serial_clock_in, serial_data_in, hold_n;
    wire         serial_data_out, serial_data_out_oe, program_busy, standby;
    wire  [31:0] prdata;
    wire         pready, pslverr;
    int          failures = 0;
    int          checks = 0;
    int          launches = 0;
    eesc_top #(.PROG_CYCLES(20'h0_0040)) dut (
        .clock, .rst, .device_select_n, .serial_clock_in, .serial_data_in, .hold_n,
        .write_guard_pin_n, .serial_data_out, .serial_data_out_oe, .program_busy,
        .standby, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
    );
    eesc_spi_master_model mst (
        .clock, .device_select_n, .serial_clock_in, .serial_data_in, .hold_n,
        .serial_data_out, .serial_data_out_oe
    );
    // 125 MHz clock
    always #4 clock = ~clock;
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // n whole bytes then tail loose bits in one select frame
    task frame(input int n, input logic [39:0] b, input int tail);
        mst.begin_frame();
        for (int k = 0; k < n; k++)
            mst.xfer(8, b[39-8*k -: 8], rx);
        if (tail > 0)
            mst.xfer(tail, 8'h00, rx);
        mst.end_frame();
    endtask
    task status(input logic [31:0] exp);
        frame(2, 40'h05_0000_0000, 0);
        check("status byte", exp, {24'h00_0000, rx});
    endtask
    // busy seen or not, polled until ready, launch count compared
    task settle(input logic launch);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check("busy at start", {31'h0, launch}, {31'h0, rd[0]});
        for (int t = 0; t < 100 && rd[0] === 1'b1; t++)
            apb(1'b0, 12'h000, 32'h0000_0000);
        check("busy at end", 32'h0000_0000, {31'h0, rd[0]});
        check("standby", 32'h0000_0001, {31'h0, standby});
        launches += launch;
        apb(1'b0, 12'h008, 32'h0000_0000);
        check("launch count", launches, rd);
    endtask
    task t_power;
        mst.xfer(8, 8'h06, rx);
        mst.end_frame();
        apb(1'b0, 12'h000, 32'h0000_0000);
        check("status before arming", 32'h0000_0170, {22'h0, rd[9:0]});
        $display("test power up done");
    endtask
    task t_regs;
        apb(1'b0, 12'h004, 32'h0000_0000);
        check("config reset", 32'h0000_0001, rd);
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check("launch count read only", 32'h0000_0000, rd);
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        check("unmapped write error", 32'h0000_0001, {31'h0, err});
        apb(1'b0, 12'h00C, 32'h0000_0000);
        check("unmapped read", 32'h0000_0000, rd);
        $display("test registers done");
    endtask
    task t_page;
        mst.set_mode(1'b1);
        frame(1, UNLOCK, 0);
        status(32'h0000_0072);
        mst.set_mode(1'b0);
        frame(5, 40'h02_001F_AA55, 0);
        settle(1'b1);
        status(32'h0000_0070);
        frame(4, 40'h03_001F_0000, 0);
        check("read first byte", 32'h0000_00AA, {24'h00_0000, rx});
        frame(4, 40'h03_0000_0000, 0);
        check("read wrapped byte", 32'h0000_0055, {24'h00_0000, rx});
        frame(4, 40'h02_0040_1100, 0);
        settle(1'b0);
        frame(1, UNLOCK, 0);
        frame(4, 40'h02_0040_1100, 3);
        settle(1'b0);
        $display("test page write done");
    endtask
    task t_guard;
        write_guard_pin_n <= 1'b0;
        frame(1, UNLOCK, 0);
        frame(2, 40'h01_8000_0000, 0);
        write_guard_pin_n <= 1'b1;
        mst.begin_frame();
        write_guard_pin_n <= 1'b0;
        mst.end_frame();
        settle(1'b1);
        status(32'h0000_00F0);
        frame(1, UNLOCK, 0);
        frame(2, 40'h01_0000_0000, 0);
        settle(1'b0);
        status(32'h0000_00F2);
        write_guard_pin_n <= 1'b1;
        frame(2, 40'h01_0400_0000, 0);
        settle(1'b1);
        status(32'h0000_0074);
        $display("test guard done");
    endtask
    task t_hold;
        write_guard_pin_n <= 1'b0;
        frame(1, UNLOCK, 0);
        frame(4, 40'h02_0300_3C00, 0);
        settle(1'b0);
        frame(4, 40'h02_02FF_3C00, 0);
        settle(1'b1);
        mst.begin_frame();
        mst.xfer(8, 8'h03, rx);
        mst.xfer(8, 8'h02, rx);
        mst.xfer(8, 8'hFF, rx);
        mst.set_hold(1'b0);
        check("output while paused", 32'h0000_0000, {31'h0, serial_data_out_oe});
        mst.set_hold(1'b1);
        mst.xfer(8, 8'h00, rx);
        mst.end_frame();
        check("read after pause", 32'h0000_003C, {24'h00_0000, rx});
        check("output deselected", 32'h0000_0000, {31'h0, serial_data_out_oe});
        $display("test hold done");
    endtask
    task summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_power();
        t_regs();
        t_page();
        t_guard();
        t_hold();
        summarize();
    end
    // watchdog
    initial begin
        repeat (60000) @(posedge clock);
        failures++;
        summarize();
    end
endmodule // eesc_top_tb_top
bind eesc_top eesc_props #(.PROG_CYCLES(PROG_CYCLES)) props (
    .clock, .rst, .device_select_n, .serial_clock_in, .hold_n, .serial_data_out,
    .serial_data_out_oe, .program_busy, .standby, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr
);
